// >>> rcr_cfg_reg.sv
// One byte-wide configuration register with a reset value.
// Assumes a synchronous active-low reset on the register clock.
`timescale 1ns/1ps
module rcr_cfg_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // Stored value
  output logic [7:0] q_o
);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      q_o <= RESET_VAL;
    else if (wr_i)
      q_o <= wdata_i;
  end

endmodule

// >>> rcr_pkg.sv
// Constants for the receiver configuration register group.
// Assumes byte-wide registers reached by an 8-bit register index.
package rcr_pkg;

  // Register offsets, in index order of the register array
  localparam int RCR_NUM_REGS = 4;
  localparam logic [7:0] RCR_OFS_FIRST_THR = 8'h14;
  localparam logic [7:0] RCR_OFS_SECOND_THR = 8'h15;
  localparam logic [7:0] RCR_OFS_BOOST_OV = 8'h2d;
  localparam logic [7:0] RCR_OFS_MODE_ROUTE = 8'h31;
  localparam logic [7:0] RCR_OFS [RCR_NUM_REGS] = '{
    RCR_OFS_FIRST_THR, RCR_OFS_SECOND_THR,
    RCR_OFS_BOOST_OV, RCR_OFS_MODE_ROUTE};

  // Reset values
  localparam logic [7:0] RCR_RST_THR = 8'h00;
  localparam logic [7:0] RCR_RST_BOOST_OV = 8'h88;
  localparam logic [7:0] RCR_RST_MODE_ROUTE = 8'h00;
  localparam logic [7:0] RCR_RST [RCR_NUM_REGS] = '{
    RCR_RST_THR, RCR_RST_THR, RCR_RST_BOOST_OV, RCR_RST_MODE_ROUTE};
  localparam logic [7:0] RCR_UNMAPPED_READ = 8'h00;

  // Field positions
  localparam int RCR_ASSERT_LSB = 4;
  localparam int RCR_DEASSERT_LSB = 2;
  localparam int RCR_OV_BIT = 3;
  localparam int RCR_MODE_LSB = 5;
  localparam int RCR_ROUTE_LSB = 0;

  // Equalizer mode and routing encodings
  typedef enum logic [1:0] {
    RCR_EQ_MANUAL = 2'h0,
    RCR_EQ_TEST = 2'h1
  } rcr_eq_mode_t;

  typedef enum logic [1:0] {
    RCR_ROUTE_FIRST_BOTH = 2'h0,
    RCR_ROUTE_FIRST_ONLY = 2'h1,
    RCR_ROUTE_SECOND_ONLY = 2'h2,
    RCR_ROUTE_SECOND_BOTH = 2'h3
  } rcr_route_t;

  // Detect threshold codes {assert, de-assert} and offsets in mV
  localparam logic [3:0] RCR_THR_NOMINAL = 4'h0;
  localparam logic [3:0] RCR_THR_MINUS2 = 4'h5;
  localparam logic [3:0] RCR_THR_PLUS5 = 4'ha;
  localparam logic [3:0] RCR_THR_PLUS3 = 4'hf;
  localparam logic signed [7:0] RCR_MV_NOMINAL = 8'sh00;
  localparam logic signed [7:0] RCR_MV_MINUS2 = 8'shfe;
  localparam logic signed [7:0] RCR_MV_PLUS5 = 8'sh05;
  localparam logic signed [7:0] RCR_MV_PLUS3 = 8'sh03;

endpackage

// >>> rcr_receiver_cfg.sv
// Receiver configuration registers: detect thresholds, boost override,
// equalizer mode and input/output routing.
// Assumes the serial management port decoder on MCLK_I presents
// register index, data and one-cycle read/write strobes.
//
// How it works
// RL1 - First input threshold fields at bits 5:2
// RL2 - Second input thresholds, same layout and codes
// RL3 - Bit 3 enables boost override, resets 0x88
// RL4 - Mode 00 manual, 01 test; others invalid
// RL5 - Routing select picks input and output fan
// RL6 - Thresholds and mode/routing reset to zero
// RL7 - Override uses programmed boost, not adapted
// RL8 - Unselected input equalizer always powered down
`timescale 1ns/1ps
module rcr_receiver_cfg #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  // Register access from the management port
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Equalizer inputs from neighbouring register groups
  input wire logic [7:0] EQ_BOOST_REG_I,
  input wire logic [7:0] EQ_ADAPT_BOOST_I,
  input wire logic EQ_PD_SELECTED_I,
  // Signal-detect thresholds
  output logic [1:0] FIRST_INPUT_ASSERT_LEVEL_O,
  output logic [1:0] FIRST_INPUT_DEASSERT_LEVEL_O,
  output logic [1:0] SECOND_INPUT_ASSERT_LEVEL_O,
  output logic [1:0] SECOND_INPUT_DEASSERT_LEVEL_O,
  output logic signed [7:0] FIRST_INPUT_OFFSET_MV_O,
  output logic signed [7:0] SECOND_INPUT_OFFSET_MV_O,
  // Equalizer control
  output logic BOOST_OVERRIDE_ENABLE_O,
  output logic [7:0] EQ_BOOST_O,
  output logic [1:0] EQ_MODE_O,
  output logic FIRST_EQ_PD_O,
  output logic SECOND_EQ_PD_O,
  // Routing
  output logic [1:0] ROUTE_SELECT_O,
  output logic SECOND_INPUT_SELECT_O,
  output logic FIRST_OUTPUT_EN_O,
  output logic SECOND_OUTPUT_EN_O
);

  if (ADDR_W < 6 || ADDR_W > 8)
  begin : g_bad_addr
    $error("ADDR_W must cover index 0x31 and fit 8 bits");
  end

  logic [7:0] regs [rcr_pkg::RCR_NUM_REGS];
  logic [7:0] wdata [rcr_pkg::RCR_NUM_REGS];
  logic [rcr_pkg::RCR_NUM_REGS-1:0] hit;
  wire [7:0] addr = 8'(REG_ADDR_I);

  // Threshold code to offset, shared by both inputs
  function automatic logic signed [7:0] thr_offset(input logic [3:0] code);
    logic signed [7:0] mv;
    mv = rcr_pkg::RCR_MV_NOMINAL;
    case (code)
      rcr_pkg::RCR_THR_MINUS2: mv = rcr_pkg::RCR_MV_MINUS2;
      rcr_pkg::RCR_THR_PLUS5: mv = rcr_pkg::RCR_MV_PLUS5;
      rcr_pkg::RCR_THR_PLUS3: mv = rcr_pkg::RCR_MV_PLUS3;
      default: mv = rcr_pkg::RCR_MV_NOMINAL;
    endcase
    return mv;
  endfunction

  // An invalid mode write keeps the old mode so the equalizer never
  // sees an undefined setting; the rest of the byte is still taken.
  wire [1:0] wr_mode = REG_WDATA_I[rcr_pkg::RCR_MODE_LSB +: 2];
  wire mode_ok = (wr_mode == rcr_pkg::RCR_EQ_MANUAL) ||
                 (wr_mode == rcr_pkg::RCR_EQ_TEST);
  wire [1:0] kept_mode = regs[3][rcr_pkg::RCR_MODE_LSB +: 2];
  wire [7:0] mode_wdata = {REG_WDATA_I[7], mode_ok ? wr_mode : kept_mode,
                           REG_WDATA_I[4:0]}; // RL4

  genvar gi;
  for (gi = 0; gi < rcr_pkg::RCR_NUM_REGS; gi++)
  begin : g_reg
    assign hit[gi] = (addr == rcr_pkg::RCR_OFS[gi]);
    assign wdata[gi] = (gi == 3) ? mode_wdata : REG_WDATA_I;
    rcr_cfg_reg #(
      .RESET_VAL(rcr_pkg::RCR_RST[gi]) // RL3 RL6
    ) u_reg (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .wr_i(REG_WR_I && hit[gi]),
      .wdata_i(wdata[gi]),
      .q_o(regs[gi])
    );
  end

  // Read back; unmapped indices read as zero
  wire [7:0] rd_mux =
    hit[0] ? regs[0] :
    hit[1] ? regs[1] :
    hit[2] ? regs[2] :
    hit[3] ? regs[3] : rcr_pkg::RCR_UNMAPPED_READ;

  // Field extraction
  wire [3:0] first_code = regs[0][rcr_pkg::RCR_DEASSERT_LSB +: 4]; // RL1
  wire [3:0] second_code = regs[1][rcr_pkg::RCR_DEASSERT_LSB +: 4]; // RL2
  wire ov_bit = regs[2][rcr_pkg::RCR_OV_BIT]; // RL3
  wire [1:0] route = regs[3][rcr_pkg::RCR_ROUTE_LSB +: 2];

  wire [1:0] next_first_assert = first_code[3:2]; // RL1
  wire [1:0] next_first_deassert = first_code[1:0];
  wire [1:0] next_second_assert = second_code[3:2]; // RL2
  wire [1:0] next_second_deassert = second_code[1:0];
  wire signed [7:0] next_first_mv = thr_offset(first_code); // RL1
  wire signed [7:0] next_second_mv = thr_offset(second_code); // RL2
  wire [7:0] next_boost = ov_bit ? EQ_BOOST_REG_I : EQ_ADAPT_BOOST_I; // RL7
  wire next_second_sel = route[1]; // RL5
  wire next_first_out = (route != rcr_pkg::RCR_ROUTE_SECOND_ONLY); // RL5
  wire next_second_out = (route != rcr_pkg::RCR_ROUTE_FIRST_ONLY); // RL5
  wire next_first_pd = next_second_sel || EQ_PD_SELECTED_I; // RL8
  wire next_second_pd = !next_second_sel || EQ_PD_SELECTED_I; // RL8

  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
      REG_RDATA_O <= rcr_pkg::RCR_UNMAPPED_READ;
    else if (REG_RD_I)
      REG_RDATA_O <= rd_mux;
  end

  // Reset images follow the register reset values, except EQ_BOOST_O, which resets to zero
  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      FIRST_INPUT_ASSERT_LEVEL_O <= 2'h0;
      FIRST_INPUT_DEASSERT_LEVEL_O <= 2'h0;
      SECOND_INPUT_ASSERT_LEVEL_O <= 2'h0;
      SECOND_INPUT_DEASSERT_LEVEL_O <= 2'h0;
      FIRST_INPUT_OFFSET_MV_O <= rcr_pkg::RCR_MV_NOMINAL;
      SECOND_INPUT_OFFSET_MV_O <= rcr_pkg::RCR_MV_NOMINAL;
      BOOST_OVERRIDE_ENABLE_O <=
        rcr_pkg::RCR_RST_BOOST_OV[rcr_pkg::RCR_OV_BIT];
      EQ_BOOST_O <= 8'h00;
      EQ_MODE_O <= rcr_pkg::RCR_EQ_MANUAL;
      ROUTE_SELECT_O <= rcr_pkg::RCR_ROUTE_FIRST_BOTH;
      SECOND_INPUT_SELECT_O <= 1'b0;
      FIRST_OUTPUT_EN_O <= 1'b1;
      SECOND_OUTPUT_EN_O <= 1'b1;
      FIRST_EQ_PD_O <= 1'b0;
      SECOND_EQ_PD_O <= 1'b1;
    end
    else
    begin
      FIRST_INPUT_ASSERT_LEVEL_O <= next_first_assert;
      FIRST_INPUT_DEASSERT_LEVEL_O <= next_first_deassert;
      SECOND_INPUT_ASSERT_LEVEL_O <= next_second_assert;
      SECOND_INPUT_DEASSERT_LEVEL_O <= next_second_deassert;
      FIRST_INPUT_OFFSET_MV_O <= next_first_mv;
      SECOND_INPUT_OFFSET_MV_O <= next_second_mv;
      BOOST_OVERRIDE_ENABLE_O <= ov_bit;
      EQ_BOOST_O <= next_boost;
      EQ_MODE_O <= kept_mode;
      ROUTE_SELECT_O <= route;
      SECOND_INPUT_SELECT_O <= next_second_sel;
      FIRST_OUTPUT_EN_O <= next_first_out;
      SECOND_OUTPUT_EN_O <= next_second_out;
      FIRST_EQ_PD_O <= next_first_pd;
      SECOND_EQ_PD_O <= next_second_pd;
    end
  end

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);

  // Register update lands on the edge after the write
  wire wr_first = REG_WR_I && (addr == rcr_pkg::RCR_OFS_FIRST_THR);
  wire wr_second = REG_WR_I && (addr == rcr_pkg::RCR_OFS_SECOND_THR);
  wire wr_ov = REG_WR_I && (addr == rcr_pkg::RCR_OFS_BOOST_OV);
  wire wr_mr = REG_WR_I && (addr == rcr_pkg::RCR_OFS_MODE_ROUTE);

  a_first_thr_write: assert property ( // RL1
    wr_first |=> ##1 FIRST_INPUT_ASSERT_LEVEL_O == $past(REG_WDATA_I[5:4], 2)
      && FIRST_INPUT_DEASSERT_LEVEL_O == $past(REG_WDATA_I[3:2], 2))
    else $error("first input threshold fields wrong");

  a_first_offset_map: assert property ( // RL1
    first_code == rcr_pkg::RCR_THR_MINUS2 |=>
      FIRST_INPUT_OFFSET_MV_O == rcr_pkg::RCR_MV_MINUS2)
    else $error("first input offset decode wrong");

  a_second_thr_write: assert property ( // RL2
    wr_second && REG_WDATA_I[5:2] == rcr_pkg::RCR_THR_PLUS5 |=> ##1
      SECOND_INPUT_OFFSET_MV_O == rcr_pkg::RCR_MV_PLUS5)
    else $error("second input threshold not applied");

  a_override_write: assert property ( // RL3
    wr_ov |=> ##1 BOOST_OVERRIDE_ENABLE_O == $past(REG_WDATA_I[3], 2))
    else $error("override bit not applied");

  a_reset_ov_value: assert property ( // RL3
    disable iff (1'b0) !RESETN_I |=> regs[2] == rcr_pkg::RCR_RST_BOOST_OV)
    else $error("override register reset value wrong");

  a_mode_invalid_kept: assert property ( // RL4
    wr_mr && !mode_ok |=> ##1 $stable(EQ_MODE_O))
    else $error("invalid mode value was taken");

  a_mode_legal: assert property ( // RL4
    EQ_MODE_O == rcr_pkg::RCR_EQ_MANUAL || EQ_MODE_O == rcr_pkg::RCR_EQ_TEST)
    else $error("mode output holds an invalid value");

  a_route_fanout: assert property ( // RL5
    route == rcr_pkg::RCR_ROUTE_SECOND_ONLY |=>
      !FIRST_OUTPUT_EN_O && SECOND_OUTPUT_EN_O && SECOND_INPUT_SELECT_O)
    else $error("second-only routing decode wrong");

  a_reset_zero: assert property ( // RL6
    disable iff (1'b0) !RESETN_I |=>
      regs[0] == 8'h00 && regs[1] == 8'h00 && regs[3] == 8'h00)
    else $error("zero-reset registers not cleared");

  a_boost_source: assert property ( // RL7
    ov_bit |=> EQ_BOOST_O == $past(EQ_BOOST_REG_I))
    else $error("override did not use programmed boost");

  a_unselected_pd: assert property ( // RL8
    route[1] |=> FIRST_EQ_PD_O)
    else $error("unselected first input equalizer powered");

  c_route_second_both: cover property (
    wr_mr && REG_WDATA_I[1:0] == rcr_pkg::RCR_ROUTE_SECOND_BOTH);
  c_test_mode: cover property (EQ_MODE_O == rcr_pkg::RCR_EQ_TEST);
  c_override_off: cover property (wr_ov && !REG_WDATA_I[3]);
  c_invalid_mode: cover property (wr_mr && !mode_ok);

endmodule

// >>> testbench.sv
// Self-checking bench for the receiver configuration registers.
// Assumes the register index/strobe port; no model on the far side.
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic rst_n;
  logic [7:0] addr, wdata, rdata, boost_reg, adapt_boost, boost, fo, so;
  logic wr, rd, pd_sel;
  logic [1:0] fa, fd, sa, sd, mode, route;
  logic ov, fpd, spd, sel2, oen1, oen2;
  logic [3:0] codes [5] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h6};
  logic [7:0] mv [5] = '{8'h00, 8'hfe, 8'h05, 8'h03, 8'h00};
  int fail_count = 0;
  int n_compared = 0;

  rcr_receiver_cfg u_rcr_receiver_cfg (
    .MCLK_I(mclk), .RESETN_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .EQ_BOOST_REG_I(boost_reg),
    .EQ_ADAPT_BOOST_I(adapt_boost), .EQ_PD_SELECTED_I(pd_sel),
    .FIRST_INPUT_ASSERT_LEVEL_O(fa), .FIRST_INPUT_DEASSERT_LEVEL_O(fd),
    .SECOND_INPUT_ASSERT_LEVEL_O(sa), .SECOND_INPUT_DEASSERT_LEVEL_O(sd),
    .FIRST_INPUT_OFFSET_MV_O(fo), .SECOND_INPUT_OFFSET_MV_O(so),
    .BOOST_OVERRIDE_ENABLE_O(ov), .EQ_BOOST_O(boost), .EQ_MODE_O(mode),
    .FIRST_EQ_PD_O(fpd), .SECOND_EQ_PD_O(spd), .ROUTE_SELECT_O(route),
    .SECOND_INPUT_SELECT_O(sel2), .FIRST_OUTPUT_EN_O(oen1),
    .SECOND_OUTPUT_EN_O(oen2)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobes are lowered one cycle after raising, so calls never collide
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge mclk);
    #1;
    wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge mclk);
    #1;
    rd = 1'b0;
    check(rdata, exp);
  endtask

  // Derived outputs trail the register by one edge
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test;
  end

  initial
  begin
    int i;
    int r;
    int p;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pd_sel = 1'b0;
    boost_reg = 8'h5a;
    adapt_boost = 8'ha5;
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    settle();
    reg_read(8'h14, 8'h00);
    reg_read(8'h15, 8'h00);
    reg_read(8'h2d, 8'h88);
    reg_read(8'h31, 8'h00);
    check(8'(ov), 8'h01);
    check(boost, 8'h5a);
    check({4'(mode), 4'(route)}, 8'h00);
    check({6'(spd), fpd, oen1 & oen2}, 8'h05);
    // Thresholds, including one code outside the listed four
    for (i = 0; i < 5; i++)
    begin
      reg_write(8'h14, {2'h2, codes[i], 2'h1});
      reg_write(8'h15, {2'h1, codes[4 - i], 2'h2});
      settle();
      check(8'({fa, fd}), 8'(codes[i]));
      check(fo, mv[i]);
      check(8'({sa, sd}), 8'(codes[4 - i]));
      check(so, mv[4 - i]);
      reg_read(8'h14, {2'h2, codes[i], 2'h1});
      reg_read(8'h15, {2'h1, codes[4 - i], 2'h2});
    end
    reg_write(8'h2d, 8'h77);
    settle();
    check({7'(ov), 1'b0} | 8'(boost == 8'ha5), 8'h01);
    reg_read(8'h2d, 8'h77);
    reg_write(8'h2d, 8'h08);
    settle();
    check({7'(ov), 1'b0} | 8'(boost == 8'h5a), 8'h03);
    // Invalid mode values leave the mode alone
    reg_write(8'h31, 8'h20);
    settle();
    check(8'(mode), 8'h01);
    reg_write(8'h31, 8'h43);
    reg_read(8'h31, 8'h23);
    reg_write(8'h31, 8'h61);
    settle();
    check({4'(mode), 4'(route)}, 8'h11);
    reg_write(8'h16, 8'hff);
    reg_read(8'h16, 8'h00);
    for (r = 0; r < 4; r++)
      for (p = 0; p < 2; p++)
      begin
        reg_write(8'h31, 8'(r));
        pd_sel = p[0];
        boost_reg = {4'(r), 4'(p)};
        settle();
        check(8'(route), 8'(r));
        check({6'(sel2), oen1, oen2}, {6'(r[1]), r != 2, r != 1});
        check({7'(fpd), spd}, {7'(r[1] | p[0]), ~r[1] | p[0]});
        check(boost, {4'(r), 4'(p)});
      end
    check(8'(mode), 8'h00);
    // Reset in mid-run must restore the registers at 0x14, 0x2d and 0x31
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    settle();
    reg_read(8'h14, 8'h00);
    reg_read(8'h2d, 8'h88);
    reg_read(8'h31, 8'h00);
    check(8'(ov), 8'h01);
    check({4'(mode), 4'(route)}, 8'h00);
    finish_test;
  end
endmodule
